//--- rtl/async_timer2.sv
// 8-bit timer with async clock option, status handshakes and an axi4-lite slave
`timescale 1ns/1ps
`include "async_timer2_defs.svh"
module async_timer2 #(
    parameter int PRESC_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_input_pin,
    input wire logic global_irq_enable,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    output async_timer2_pkg::irq_pair_t irq_req,
    output logic waveform_output_pin,
    output logic ext_clock_input_enable,
    output logic crystal_osc_enable
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [7:0] word_index(input logic [31:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    function automatic logic presc_tap(input logic [2:0] cs, input logic [PRESC_W-1:0] p,
                                       input logic tick);
        logic hit;
        hit = 1'b0;
        case (cs)
            3'h1: hit = 1'b1;
            3'h2: hit = &p[2:0];
            3'h3: hit = &p[4:0];
            3'h4: hit = &p[5:0];
            3'h5: hit = &p[6:0];
            3'h6: hit = &p[7:0];
            3'h7: hit = &p[9:0];
            default: hit = 1'b0;
        endcase
        presc_tap = tick & hit;
    endfunction : presc_tap

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    async_timer2_pkg::wr_state_t wr_state_ff;
    logic [31:0] awaddr_ff;
    logic aw_got_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_got_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] count_ff;
    logic [7:0] compare_ff;
    async_timer2_pkg::timer_ctrl_t ctrl_ff;
    logic [7:0] count_tmp_ff;
    logic [7:0] compare_tmp_ff;
    async_timer2_pkg::timer_ctrl_t ctrl_tmp_ff;
    logic cnt_busy_ff;
    logic cmp_busy_ff;
    logic ctrl_busy_ff;
    logic async_sel_ff;
    logic ext_clk_ff;
    logic [1:0] mask_ff;
    logic ovf_flag_ff;
    logic cmp_flag_ff;
    logic tsm_ff;
    logic psr_ff;
    logic [PRESC_W-1:0] presc_ff;
    logic osc_prev_ff;
    logic block_ff;
    logic count_up_ff;
    logic wave_ff;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic [7:0] wbyte;
    logic wr_en;

    assign s_axi_awready = !aw_got_ff && (wr_state_ff != async_timer2_pkg::WR_RESP);
    assign s_axi_wready = !w_got_ff && (wr_state_ff != async_timer2_pkg::WR_RESP);
    assign s_axi_bvalid = (wr_state_ff == async_timer2_pkg::WR_RESP);
    assign s_axi_bresp = bresp_ff;
    assign wr_fire = (wr_state_ff == async_timer2_pkg::WR_COLLECT) && aw_got_ff && w_got_ff;
    assign wr_idx = word_index(awaddr_ff);
    assign wbyte = wdata_ff[7:0];
    assign wr_en = wr_fire && wstrb_ff[0];
    assign wr_hit = (wr_idx == `IDX_IRQ_FLAG) || (wr_idx == `IDX_GENERAL_CTRL)
        || (wr_idx == `IDX_IRQ_MASK) || (wr_idx == `IDX_TIMER_CTRL)
        || (wr_idx == `IDX_COUNT_VALUE) || (wr_idx == `IDX_COMPARE_VALUE)
        || (wr_idx == `IDX_ASYNC_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= async_timer2_pkg::WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            case (wr_state_ff)
                async_timer2_pkg::WR_IDLE: begin
                    if ((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready)) begin
                        wr_state_ff <= async_timer2_pkg::WR_COLLECT;
                    end
                end
                async_timer2_pkg::WR_COLLECT: begin
                    if (wr_fire) begin
                        wr_state_ff <= async_timer2_pkg::WR_RESP;
                        aw_got_ff <= 1'b0;
                        w_got_ff <= 1'b0;
                        bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                    end
                end
                async_timer2_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_ff <= async_timer2_pkg::WR_IDLE;
                    end
                end
                default: wr_state_ff <= async_timer2_pkg::WR_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [7:0] rd_idx;

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rd_idx = word_index(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            if (rd_idx == `IDX_IRQ_FLAG) begin
                rdata_ff[1:0] <= {cmp_flag_ff, ovf_flag_ff};
            end else if (rd_idx == `IDX_GENERAL_CTRL) begin
                rdata_ff[7:0] <= {tsm_ff, 5'h00, psr_ff, 1'b0};
            end else if (rd_idx == `IDX_IRQ_MASK) begin
                rdata_ff[1:0] <= mask_ff;
            end else if (rd_idx == `IDX_TIMER_CTRL) begin
                rdata_ff[7:0] <= {1'b0, ctrl_tmp_ff[6:0]};
            end else if (rd_idx == `IDX_COUNT_VALUE) begin
                rdata_ff[7:0] <= count_ff;
            end else if (rd_idx == `IDX_COMPARE_VALUE) begin
                rdata_ff[7:0] <= compare_tmp_ff;
            end else if (rd_idx == `IDX_ASYNC_STATUS) begin
                rdata_ff[4:0] <= {ext_clk_ff, async_sel_ff, cnt_busy_ff, cmp_busy_ff,
                                  ctrl_busy_ff};
            end else begin
                rresp_ff <= `RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // timer clock source and prescaler
    // ------------------------------------------------------------
    logic tick;
    logic count_en;
    logic psr_act;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_cmp;
    logic wr_gen;

    assign wr_ctrl = wr_en && (wr_idx == `IDX_TIMER_CTRL);
    assign wr_cnt = wr_en && (wr_idx == `IDX_COUNT_VALUE);
    assign wr_cmp = wr_en && (wr_idx == `IDX_COMPARE_VALUE);
    assign wr_gen = wr_en && (wr_idx == `IDX_GENERAL_CTRL);
    assign tick = async_sel_ff ? (osc_input_pin && !osc_prev_ff) : 1'b1;
    assign psr_act = psr_ff && tick;
    assign count_en = presc_tap(ctrl_ff.clock_select_field, presc_ff, tick);
    assign ext_clock_input_enable = ext_clk_ff && async_sel_ff;
    assign crystal_osc_enable = async_sel_ff && !ext_clk_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_input_pin;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_ff <= '0;
        end else if (psr_act) begin
            presc_ff <= '0;
        end else if (tick) begin
            presc_ff <= presc_ff + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psr_ff <= 1'b0;
            tsm_ff <= 1'b0;
        end else begin
            if (wr_gen) begin
                tsm_ff <= wbyte[`BIT_TSM];
            end
            if (wr_gen && wbyte[`BIT_PSR]) begin
                psr_ff <= 1'b1;
            end else if (psr_act && !tsm_ff) begin
                psr_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // async status and temporary storage
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            async_sel_ff <= 1'b0;
            ext_clk_ff <= 1'b0;
            mask_ff <= 2'h0;
        end else begin
            if (wr_en && (wr_idx == `IDX_ASYNC_STATUS)) begin
                async_sel_ff <= wbyte[`BIT_AS];
                ext_clk_ff <= wbyte[`BIT_EXT_CLOCK_INPUT_ENABLE];
            end
            if (wr_en && (wr_idx == `IDX_IRQ_MASK)) begin
                mask_ff <= wbyte[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_tmp_ff <= `RST_BYTE;
            compare_tmp_ff <= `RST_BYTE;
            ctrl_tmp_ff <= '0;
            cnt_busy_ff <= 1'b0;
            cmp_busy_ff <= 1'b0;
            ctrl_busy_ff <= 1'b0;
        end else begin
            if (wr_cnt) begin
                count_tmp_ff <= wbyte;
                cnt_busy_ff <= async_sel_ff;
            end else if (tick) begin
                cnt_busy_ff <= 1'b0;
            end
            if (wr_cmp) begin
                compare_tmp_ff <= wbyte;
                cmp_busy_ff <= async_sel_ff;
            end else if (tick) begin
                cmp_busy_ff <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_tmp_ff <= wbyte;
                ctrl_busy_ff <= async_sel_ff;
            end else if (tick) begin
                ctrl_busy_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // live registers and counter
    // ------------------------------------------------------------
    logic [1:0] wgm;
    logic [7:0] top;
    logic match;
    logic force_cmp;
    logic ovf_evt;
    logic at_top;

    assign wgm = {ctrl_ff.wgm1, ctrl_ff.wgm0};
    assign top = (wgm == `WGM_CTC) ? compare_ff : `COUNT_MAX;
    assign at_top = (count_ff == top);
    assign match = count_en && (count_ff == compare_ff) && !block_ff;
    assign force_cmp = wr_ctrl && !async_sel_ff && wbyte[`BIT_FORCE] && !wgm[0];
    assign ovf_evt = count_en && ((wgm == `WGM_PHASE) ?
        (!count_up_ff && (count_ff == `COUNT_BOTTOM)) : (count_ff == `COUNT_MAX));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_ff <= `RST_BYTE;
            ctrl_ff <= '0;
        end else begin
            if (wr_cmp && !async_sel_ff) begin
                compare_ff <= wbyte;
            end else if (cmp_busy_ff && tick) begin
                compare_ff <= compare_tmp_ff;
            end
            if (wr_ctrl && !async_sel_ff) begin
                ctrl_ff <= {1'b0, wbyte[6:0]};
            end else if (ctrl_busy_ff && tick) begin
                ctrl_ff <= ctrl_tmp_ff;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= `RST_BYTE;
            count_up_ff <= 1'b1;
            block_ff <= 1'b0;
        end else begin
            if ((wr_cnt && !async_sel_ff) || (cnt_busy_ff && tick)) begin
                count_ff <= async_sel_ff ? count_tmp_ff : wbyte;
                block_ff <= 1'b1;
            end else if (count_en) begin
                block_ff <= 1'b0;
                if (wgm == `WGM_PHASE) begin
                    if (count_up_ff && (count_ff == `COUNT_MAX)) begin
                        count_up_ff <= 1'b0;
                        count_ff <= count_ff - 1'b1;
                    end else if (!count_up_ff && (count_ff == `COUNT_BOTTOM)) begin
                        count_up_ff <= 1'b1;
                        count_ff <= count_ff + 1'b1;
                    end else begin
                        count_ff <= count_up_ff ? count_ff + 1'b1 : count_ff - 1'b1;
                    end
                end else begin
                    count_up_ff <= 1'b1;
                    count_ff <= at_top ? `COUNT_BOTTOM : count_ff + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // waveform output
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_ff <= 1'b0;
        end else if (wgm[0]) begin
            if (match && ctrl_ff.com[1] && !(compare_ff == `COUNT_MAX)) begin
                wave_ff <= ctrl_ff.com[0] ^ ((wgm == `WGM_PHASE) && !count_up_ff);
            end else if (count_en && (wgm == `WGM_FAST) && at_top && ctrl_ff.com[1]) begin
                wave_ff <= !ctrl_ff.com[0];
            end
        end else if (match || force_cmp) begin
            case (ctrl_ff.com)
                `COM_TOGGLE: wave_ff <= !wave_ff;
                `COM_CLEAR: wave_ff <= 1'b0;
                `COM_SET: wave_ff <= 1'b1;
                default: wave_ff <= wave_ff;
            endcase
        end
    end

    assign waveform_output_pin = wave_ff;

    // ------------------------------------------------------------
    // flags and interrupt requests
    // ------------------------------------------------------------
    logic clr_cmp;
    logic clr_ovf;

    assign clr_cmp = compare_vector_ack || (wr_en && (wr_idx == `IDX_IRQ_FLAG) && wbyte[`BIT_CMP]);
    assign clr_ovf = overflow_vector_ack
        || (wr_en && (wr_idx == `IDX_IRQ_FLAG) && wbyte[`BIT_OVF]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_flag_ff <= 1'b0;
            ovf_flag_ff <= 1'b0;
        end else begin
            cmp_flag_ff <= match || (cmp_flag_ff && !clr_cmp);
            ovf_flag_ff <= ovf_evt || (ovf_flag_ff && !clr_ovf);
        end
    end

    assign irq_req.compare_irq = cmp_flag_ff && mask_ff[`BIT_CMP] && global_irq_enable;
    assign irq_req.overflow_irq = ovf_flag_ff && mask_ff[`BIT_OVF] && global_irq_enable;

endmodule : async_timer2

//--- rtl/async_timer2_defs.svh
// register indices, field positions, reset values and encodings of the timer block
`ifndef ASYNC_TIMER2_DEFS_SVH
`define ASYNC_TIMER2_DEFS_SVH

// register indices, byte address is four times the index
`define IDX_IRQ_FLAG 8'h37
`define IDX_GENERAL_CTRL 8'h43
`define IDX_IRQ_MASK 8'h70
`define IDX_TIMER_CTRL 8'hB0
`define IDX_COUNT_VALUE 8'hB2
`define IDX_COMPARE_VALUE 8'hB3
`define IDX_ASYNC_STATUS 8'hB6

// field positions
`define BIT_OVF 0
`define BIT_CMP 1
`define BIT_CTRL_BUSY 0
`define BIT_CMP_BUSY 1
`define BIT_CNT_BUSY 2
`define BIT_AS 3
`define BIT_EXT_CLOCK_INPUT_ENABLE 4
`define BIT_PSR 1
`define BIT_TSM 7
`define BIT_FORCE 7

// reset values
`define RST_BYTE 8'h00

// waveform modes and output actions
`define WGM_NORMAL 2'h0
`define WGM_PHASE 2'h1
`define WGM_CTC 2'h2
`define WGM_FAST 2'h3
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/async_timer2_pkg.sv
// types of the timer block
package async_timer2_pkg;

    typedef struct packed {
        logic force_cmp;
        logic wgm0;
        logic [1:0] com;
        logic wgm1;
        logic [2:0] clock_select_field;
    } timer_ctrl_t;

    typedef struct packed {
        logic compare_irq;
        logic overflow_irq;
    } irq_pair_t;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_COLLECT = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;

endpackage : async_timer2_pkg

//--- bench/async_timer2_checker.sv
// port assertions for the timer block
`timescale 1ns/1ps
module async_timer2_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic global_irq_enable,
    input wire async_timer2_pkg::irq_pair_t irq_req,
    input wire logic ext_clock_input_enable,
    input wire logic crystal_osc_enable
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence resp_up;
    ##[1:2] s_axi_bvalid;
endsequence
chk_write_answer: assert property (wr_taken |-> resp_up)
    else $error("write response late");
chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
chk_cmp_gate: assert property (irq_req.compare_irq |-> global_irq_enable)
    else $error("compare irq without global enable");
chk_ovf_gate: assert property (irq_req.overflow_irq |-> global_irq_enable)
    else $error("overflow irq without global enable");
chk_irq_drop: assert property ($fell(global_irq_enable) |-> irq_req == 2'h0)
    else $error("irq stays after global disable");
chk_osc_excl: assert property (ext_clock_input_enable |-> !crystal_osc_enable)
    else $error("crystal runs with external input");
endmodule : async_timer2_checker

//--- bench/async_timer2_bench.sv
// self-checking bench of the timer block
`timescale 1ns/1ps
`include "async_timer2_defs.svh"
module async_timer2_bench;
// ----------------------------------------
// signals
// ----------------------------------------
logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic osc_input_pin, global_irq_enable, compare_vector_ack, overflow_vector_ack;
logic waveform_output_pin, ext_clock_input_enable, crystal_osc_enable;
async_timer2_pkg::irq_pair_t irq_req;
int err_total;
int compares;

async_timer2 #(.PRESC_W(10)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .osc_input_pin, .global_irq_enable, .compare_vector_ack,
    .overflow_vector_ack, .irq_req, .waveform_output_pin, .ext_clock_input_enable,
    .crystal_osc_enable
);

initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
end
// ----------------------------------------
// bus and check tasks
// ----------------------------------------
task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    compares++;
    if (got !== exp) begin
        err_total++;
        $display("[ERR] %s exp %h got %h", what, exp, got);
    end
endtask : chk

task automatic tmo(input string what);
    err_total++;
    $display("[ERR] %s exp handshake got timeout", what);
    results();
endtask : tmo

task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] erp = `RESP_OKAY);
    logic a, w, b;
    logic [1:0] r;
    b = 1'h0;
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40 && !b; n++) begin
        @(negedge aclk);
        a = s_axi_awready & s_axi_awvalid;
        w = s_axi_wready & s_axi_wvalid;
        b = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge aclk);
        if (a) s_axi_awvalid <= 1'h0;
        if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    if (!b) tmo("write");
    chk("bresp", {32'h0, erp}, {32'h0, r});
endtask : wr

task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] erp = `RESP_OKAY);
    logic a, v;
    logic [33:0] got;
    v = 1'h0;
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40 && !v; n++) begin
        @(negedge aclk);
        a = s_axi_arready & s_axi_arvalid;
        v = s_axi_rvalid;
        got = {s_axi_rresp, s_axi_rdata};
        @(posedge aclk);
        if (a) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    if (!v) tmo("read");
    chk(what, {erp, 24'h0, d}, got);
endtask : rd_chk

task automatic osc_tick;
    osc_input_pin <= 1'h1;
    repeat (4) @(posedge aclk);
    osc_input_pin <= 1'h0;
    repeat (4) @(posedge aclk);
endtask : osc_tick

task automatic pin_chk(input string what, input logic [1:0] exp);
    @(negedge aclk);
    if (what == "irq") chk(what, {32'h0, exp}, {32'h0, irq_req});
    else if (what == "wave") chk(what, {32'h0, exp}, {33'h0, waveform_output_pin});
    else chk(what, {32'h0, exp}, {32'h0, ext_clock_input_enable, crystal_osc_enable});
    @(posedge aclk);
endtask : pin_chk
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_regs;
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h00);
    rd_chk("mask", `IDX_IRQ_MASK, 8'h00);
    rd_chk("status", `IDX_ASYNC_STATUS, 8'h00);
    rd_chk("general", `IDX_GENERAL_CTRL, 8'h00);
    rd_chk("unmapped", 8'h01, 8'h00, `RESP_SLVERR);
    wr(8'h01, 8'hFF, `RESP_SLVERR);
    wr(`IDX_TIMER_CTRL, 8'h00);
    wr(`IDX_COUNT_VALUE, 8'hA5);
    rd_chk("count", `IDX_COUNT_VALUE, 8'hA5);
    wr(`IDX_COUNT_VALUE, 8'h5A);
    rd_chk("count", `IDX_COUNT_VALUE, 8'h5A);
    $display("test regs done");
endtask : t_regs

task automatic t_psr;
    wr(`IDX_GENERAL_CTRL, 8'h02);
    rd_chk("general", `IDX_GENERAL_CTRL, 8'h00);
    wr(`IDX_GENERAL_CTRL, 8'h82);
    rd_chk("general", `IDX_GENERAL_CTRL, 8'h82);
    wr(`IDX_GENERAL_CTRL, 8'h00);
    rd_chk("general", `IDX_GENERAL_CTRL, 8'h00);
    $display("test prescaler done");
endtask : t_psr

task automatic t_irq;
    wr(`IDX_COMPARE_VALUE, 8'h40);
    wr(`IDX_COUNT_VALUE, 8'h40);
    wr(`IDX_TIMER_CTRL, 8'h31);
    wr(`IDX_TIMER_CTRL, 8'h00);
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h00);
    pin_chk("wave", 2'h0);
    wr(`IDX_COUNT_VALUE, 8'h3C);
    wr(`IDX_IRQ_MASK, 8'h03);
    global_irq_enable <= 1'h1;
    wr(`IDX_TIMER_CTRL, 8'h31);
    repeat (300) @(posedge aclk);
    wr(`IDX_TIMER_CTRL, 8'h00);
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h03);
    pin_chk("wave", 2'h1);
    pin_chk("irq", 2'h3);
    global_irq_enable <= 1'h0;
    pin_chk("irq", 2'h0);
    global_irq_enable <= 1'h1;
    wr(`IDX_IRQ_MASK, 8'h01);
    pin_chk("irq", 2'h1);
    wr(`IDX_IRQ_FLAG, 8'h00);
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h03);
    compare_vector_ack <= 1'h1;
    @(posedge aclk);
    compare_vector_ack <= 1'h0;
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h01);
    wr(`IDX_IRQ_FLAG, 8'h01);
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h00);
    pin_chk("irq", 2'h0);
    $display("test irq done");
endtask : t_irq

task automatic t_phase;
    wr(`IDX_COUNT_VALUE, 8'hF0);
    wr(`IDX_TIMER_CTRL, 8'h41);
    repeat (100) @(posedge aclk);
    wr(`IDX_TIMER_CTRL, 8'h40);
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h00);
    wr(`IDX_COUNT_VALUE, 8'h08);
    wr(`IDX_TIMER_CTRL, 8'h41);
    repeat (20) @(posedge aclk);
    wr(`IDX_TIMER_CTRL, 8'h40);
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h01);
    pin_chk("irq", 2'h1);
    overflow_vector_ack <= 1'h1;
    @(posedge aclk);
    overflow_vector_ack <= 1'h0;
    rd_chk("flags", `IDX_IRQ_FLAG, 8'h00);
    wr(`IDX_TIMER_CTRL, 8'h00);
    $display("test phase done");
endtask : t_phase

task automatic t_async;
    wr(`IDX_ASYNC_STATUS, 8'h10);
    pin_chk("osc", 2'h0);
    wr(`IDX_ASYNC_STATUS, 8'h18);
    pin_chk("osc", 2'h2);
    wr(`IDX_ASYNC_STATUS, 8'h00);
    wr(`IDX_ASYNC_STATUS, 8'h08);
    pin_chk("osc", 2'h1);
    wr(`IDX_COUNT_VALUE, 8'h33);
    osc_tick();
    rd_chk("status", `IDX_ASYNC_STATUS, 8'h08);
    wr(`IDX_COMPARE_VALUE, 8'h55);
    rd_chk("status", `IDX_ASYNC_STATUS, 8'h0A);
    rd_chk("compare", `IDX_COMPARE_VALUE, 8'h55);
    wr(`IDX_COUNT_VALUE, 8'h20);
    rd_chk("status", `IDX_ASYNC_STATUS, 8'h0E);
    rd_chk("count", `IDX_COUNT_VALUE, 8'h33);
    wr(`IDX_TIMER_CTRL, 8'h12);
    rd_chk("status", `IDX_ASYNC_STATUS, 8'h0F);
    rd_chk("control", `IDX_TIMER_CTRL, 8'h12);
    osc_tick();
    rd_chk("status", `IDX_ASYNC_STATUS, 8'h08);
    rd_chk("count", `IDX_COUNT_VALUE, 8'h20);
    $display("test async done");
endtask : t_async
// ----------------------------------------
// main sequence
// ----------------------------------------
task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask : results

initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    {osc_input_pin, global_irq_enable, compare_vector_ack, overflow_vector_ack} = 4'h0;
    err_total = 0;
    compares = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_psr();
    t_irq();
    t_phase();
    t_async();
    results();
end
endmodule : async_timer2_bench

bind async_timer2 async_timer2_checker i_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .global_irq_enable, .irq_req,
    .ext_clock_input_enable, .crystal_osc_enable
);
